// ==== rtl/apcf_regs.svh ====
`ifndef APCF_REGS_SVH
`define APCF_REGS_SVH
// register byte offsets
`define APCF_CTRL_OFS 6'h00
`define APCF_CAP_OFS 6'h04
`define APCF_OFF0_OFS 6'h08
`define APCF_RES0_OFS 6'h18
`define APCF_IRQ_STAT_OFS 6'h28
`define APCF_IRQ_MASK_OFS 6'h2c
`define APCF_PHASE_OFS 6'h30
// field positions
`define APCF_SPLIT_BIT 0
`define APCF_THREE_LED_BIT 1
`define APCF_CAP_PRI_LSB 0
`define APCF_CAP_SEC_LSB 4
`define APCF_CAP_W 3
`define APCF_MAG_W 5
`define APCF_POL_BIT 7
`define APCF_CODE_W 22
`define APCF_RES_W 24
`define APCF_NPHASE 4
`define APCF_READY_LSB 0
`define APCF_RANGE_LSB 4
// reset values
`define APCF_CTRL_RST 2'h0
`define APCF_CAP_RST 3'h0
`define APCF_MAG_RST 5'h00
`define APCF_IRQ_RST 8'h00
`endif

// ==== rtl/apcf_pkg.sv ====
package apcf_pkg;
    // what the photodiode sees during the current phase
    typedef enum logic [2:0] {
        PK_LED2,
        PK_AMB2,
        PK_LED3,
        PK_LED1,
        PK_AMB1
    } apcf_phase_kind_type;
endpackage : apcf_pkg

// ==== rtl/apcf_top.sv ====
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`include "apcf_regs.svh"
module apcf_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [1:0] phase_sel,
    input wire logic conv_valid,
    input wire logic [1:0] conv_phase,
    input wire logic [21:0] conv_code,
    input wire logic conv_over,
    input wire logic conv_under,
    output logic [2:0] active_cap_select,
    output logic [4:0] offset_current_magnitude,
    output logic offset_current_polarity,
    output apcf_pkg::apcf_phase_kind_type phase_kind,
    output logic irq
);
    logic [1:0] ctrl_reg;
    logic [2:0] cap_pri_reg;
    logic [2:0] cap_sec_reg;
    logic [4:0] mag_reg [0:3];
    logic pol_reg [0:3];
    logic [23:0] res_reg [0:3];
    logic [7:0] stat_reg;
    logic [7:0] mask_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [2:0] cap_out_reg;
    logic [4:0] mag_out_reg;
    logic pol_out_reg;
    apcf_pkg::apcf_phase_kind_type kind_reg;
    logic irq_reg;

    // bus decode: a write lands only on the edge that completes it
    wire req = avs_read | avs_write;
    wire wr_go = avs_write & ~wait_reg;
    wire [3:0] widx = avs_address[5:2];
    wire hit_ctrl = avs_address == `APCF_CTRL_OFS;
    wire hit_cap = avs_address == `APCF_CAP_OFS;
    wire hit_stat = avs_address == `APCF_IRQ_STAT_OFS;
    wire hit_mask = avs_address == `APCF_IRQ_MASK_OFS;
    wire hit_phase = avs_address == `APCF_PHASE_OFS;
    // word indices kept at full address width, then cut on purpose
    wire [5:0] off_word = `APCF_OFF0_OFS >> 2;
    wire [5:0] res_word = `APCF_RES0_OFS >> 2;
    wire [3:0] off_base = off_word[3:0];
    wire [3:0] res_base = res_word[3:0];
    wire hit_off = avs_address[1:0] == 2'h0 && widx >= off_base
        && widx < off_base + 4'h4;
    wire hit_res = avs_address[1:0] == 2'h0 && widx >= res_base
        && widx < res_base + 4'h4;
    wire [3:0] off_d = widx - off_base;
    wire [3:0] res_d = widx - res_base;
    wire [1:0] off_i = off_d[1:0];
    wire [1:0] res_i = res_d[1:0];
    wire off_wr = wr_go && hit_off;
    wire stat_wr = wr_go && hit_stat;
    // write fields of an offset word
    wire [4:0] wr_mag = avs_writedata[`APCF_MAG_W-1:0];
    wire wr_pol = avs_writedata[`APCF_POL_BIT];

    // both capacitor fields share one plain code mapping
    wire [2:0] wr_pri = avs_writedata[`APCF_CAP_PRI_LSB +: 3];
    wire [2:0] wr_sec = avs_writedata[`APCF_CAP_SEC_LSB +: 3];
    wire split = ctrl_reg[`APCF_SPLIT_BIT];
    wire three_led = ctrl_reg[`APCF_THREE_LED_BIT];

    // result formatting; over-range wins if the converter flags both
    wire [23:0] fmt_over = {3'b001, 21'h1fffff};
    wire [23:0] fmt_under = {3'b110, 21'h000000};
    wire [23:0] fmt_in = {{2{conv_code[21]}}, conv_code};
    wire [23:0] fmt_word = conv_over ? fmt_over
        : (conv_under ? fmt_under : fmt_in);
    wire out_range = conv_over | conv_under;

    // events: result ready per phase, range error per phase
    wire [3:0] ev_ready = conv_valid ? (4'h1 << conv_phase) : 4'h0;
    wire [3:0] ev_range = out_range ? ev_ready : 4'h0;
    wire [7:0] ev_all = {ev_range, ev_ready};
    wire [7:0] w1c = stat_wr ? avs_writedata[7:0] : 8'h00;
    // a set in the same cycle as its clear survives, so no event is lost
    wire [7:0] stat_next = (stat_reg & ~w1c) | ev_all;
    // irq lags status by one edge so that it leaves a flip-flop cleanly
    wire irq_cond = |(stat_reg & mask_reg);

    // capacitor code for the live phase; second field gated by split
    wire sec_phase = phase_sel < 2'h2;
    wire [2:0] cap_next = (split && sec_phase)
        ? cap_sec_reg : cap_pri_reg;

    // label of the live phase; slot 1 is LED3 instead of ambient 2 when three_led is set
    wire apcf_pkg::apcf_phase_kind_type kind_next =
        phase_sel == 2'h0 ? apcf_pkg::PK_LED2 :
        phase_sel == 2'h1 ? (three_led ? apcf_pkg::PK_LED3
                                       : apcf_pkg::PK_AMB2) :
        phase_sel == 2'h2 ? apcf_pkg::PK_LED1 :
        apcf_pkg::PK_AMB1;

    // read mux; unmapped addresses read as zero
    wire [31:0] rd_off = {24'h0, pol_reg[off_i], 2'h0, mag_reg[off_i]};
    wire [31:0] rd_next =
        hit_ctrl ? {30'h0, ctrl_reg} :
        hit_cap ? {25'h0, cap_sec_reg, 1'b0, cap_pri_reg} :
        hit_off ? rd_off :
        hit_res ? {8'h0, res_reg[res_i]} :
        hit_stat ? {24'h0, stat_reg} :
        hit_mask ? {24'h0, mask_reg} :
        hit_phase ? {27'h0, phase_sel, kind_reg} :
        32'h0;

    // one wait cycle per access, then a single-cycle release
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end else begin
            wait_reg <= ~(req & wait_reg);
            if (avs_read && wait_reg) begin
                rdata_reg <= rd_next;
            end
        end
    end

    // control and capacitor fields
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= `APCF_CTRL_RST;
            cap_pri_reg <= `APCF_CAP_RST;
            cap_sec_reg <= `APCF_CAP_RST;
        end else if (wr_go && hit_ctrl) begin
            ctrl_reg <= avs_writedata[1:0];
        end else if (wr_go && hit_cap) begin
            cap_pri_reg <= wr_pri;
            cap_sec_reg <= wr_sec;
        end
    end

    // per-phase offset settings and results
    genvar g;
    generate
        for (g = 0; g < `APCF_NPHASE; g = g + 1) begin : g_ph
            always_ff @(posedge clk) begin
                if (rst) begin
                    mag_reg[g] <= `APCF_MAG_RST;
                    pol_reg[g] <= 1'b0;
                end else if (off_wr && off_i == g) begin
                    mag_reg[g] <= wr_mag;
                    pol_reg[g] <= wr_pol;
                end
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    res_reg[g] <= 24'h000000;
                end else if (conv_valid && conv_phase == g) begin
                    res_reg[g] <= fmt_word;
                end
            end
        end
    endgenerate

    // interrupt status and mask
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_reg <= `APCF_IRQ_RST;
            mask_reg <= `APCF_IRQ_RST;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            if (wr_go && hit_mask) begin
                mask_reg <= avs_writedata[7:0];
            end
            irq_reg <= irq_cond;
        end
    end

    // analog drive for the live phase, registered to keep it glitch free
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_out_reg <= `APCF_CAP_RST;
            mag_out_reg <= `APCF_MAG_RST;
            pol_out_reg <= 1'b0;
            kind_reg <= apcf_pkg::PK_LED2;
        end else begin
            cap_out_reg <= cap_next;
            mag_out_reg <= mag_reg[phase_sel];
            pol_out_reg <= pol_reg[phase_sel];
            kind_reg <= kind_next;
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign active_cap_select = cap_out_reg;
    assign offset_current_magnitude = mag_out_reg;
    assign offset_current_polarity = pol_out_reg;
    assign phase_kind = kind_reg;
    assign irq = irq_reg;

    // checks on the driven outputs and on the stored result, status and offset registers
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_cap_no_split: assert property (
        !split |=> active_cap_select == $past(cap_pri_reg))
        else $error("primary cap not applied with split off");
    a_cap_split_sec: assert property (
        split && phase_sel < 2'h2 |=> active_cap_select == $past(cap_sec_reg))
        else $error("second cap not applied in split phase");
    a_cap_split_pri: assert property (
        split && phase_sel > 2'h1 |=> active_cap_select == $past(cap_pri_reg))
        else $error("primary cap not applied in split phase");
    a_sec_ignored: assert property (
        !split && !$past(split) && $stable(cap_pri_reg) && !$past(rst)
        |=> $stable(active_cap_select))
        else $error("second cap field leaked with split off");
    a_offset_phase: assert property (
        1'b1 |=> offset_current_magnitude == mag_reg[$past(phase_sel)]
            || $past(off_wr))
        else $error("offset magnitude not from live phase");
    a_pol_neg: assert property (
        pol_reg[phase_sel] |=> offset_current_polarity)
        else $error("negative offset polarity not applied");
    a_result_ext: assert property (
        conv_valid && !out_range
        |=> res_reg[$past(conv_phase)][21:0] == $past(conv_code)
            && res_reg[$past(conv_phase)][23:22]
            == {2{res_reg[$past(conv_phase)][21]}})
        else $error("in-range result not sign extended");
    a_result_over: assert property (
        conv_valid && conv_over
        |=> res_reg[$past(conv_phase)][23:21] == 3'b001)
        else $error("over-range status wrong");
    a_result_under: assert property (
        conv_valid && conv_under && !conv_over
        |=> res_reg[$past(conv_phase)][23:21] == 3'b110)
        else $error("under-range status wrong");
    a_phase_led3: assert property (
        three_led && phase_sel == 2'h1 |=> phase_kind == apcf_pkg::PK_LED3)
        else $error("slot 1 not LED3 in three-LED mode");
    a_ready_sticky: assert property (
        conv_valid |=> stat_reg[$past(conv_phase)] ##1 irq == $past(irq_cond))
        else $error("ready flag lost or irq wrong");
    a_bus_answer: assert property (
        req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not in one cycle");
    a_read_idle: assert property (
        !req |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    a_off_write: assert property (
        off_wr |=> mag_reg[$past(off_i)] == $past(wr_mag)
            && pol_reg[$past(off_i)] == $past(wr_pol))
        else $error("offset setting not stored for its phase");
    a_pol_pos: assert property (
        !pol_reg[phase_sel] |=> !offset_current_polarity)
        else $error("positive offset polarity not applied");

    // phase labels for slots 0, 2 and 3, and for slot 1 in two-LED mode
    a_kind_first: assert property (
        phase_sel == 2'h0 |=> phase_kind == apcf_pkg::PK_LED2)
        else $error("slot 0 not LED2");
    a_kind_amb2: assert property (
        !three_led && phase_sel == 2'h1 |=> phase_kind == apcf_pkg::PK_AMB2)
        else $error("slot 1 not ambient 2 in two-LED mode");
    a_kind_third: assert property (
        phase_sel == 2'h2 |=> phase_kind == apcf_pkg::PK_LED1)
        else $error("slot 2 not LED1");
    a_kind_last: assert property (
        phase_sel == 2'h3 |=> phase_kind == apcf_pkg::PK_AMB1)
        else $error("slot 3 not ambient 1");

    // result words stand between results, status bits are sticky
    a_result_inrange: assert property (
        conv_valid && !out_range
        |=> res_reg[$past(conv_phase)][23:21] == 3'b000
            || res_reg[$past(conv_phase)][23:21] == 3'b111)
        else $error("in-range status bits wrong");
    a_result_stand: assert property (
        !conv_valid |=> $stable(res_reg[0]) && $stable(res_reg[1])
            && $stable(res_reg[2]) && $stable(res_reg[3]))
        else $error("result word changed without a result");
    a_stat_set: assert property (
        1'b1 |=> (stat_reg & $past(ev_all)) == $past(ev_all))
        else $error("status event lost");
    a_stat_clear: assert property (
        stat_wr |=> (stat_reg & $past(w1c) & ~$past(ev_all)) == 8'h00)
        else $error("status bit not cleared by a one");
    a_irq_level: assert property (
        1'b1 |=> irq == $past(irq_cond))
        else $error("irq does not follow unmasked status");

    c_split_use: cover property (split && phase_sel == 2'h0 ##1 split);
    c_over_hit: cover property (conv_valid && conv_over);
    c_under_hit: cover property (conv_valid && conv_under && !conv_over);
    c_three_led: cover property (three_led && phase_sel == 2'h1);
    c_irq_rise: cover property ($rose(irq));
endmodule : apcf_top

// ==== verification/apcf_conv_model.sv ====
`timescale 1ns/1ps
// behavioural converter: one result per request, one cycle after it
module apcf_conv_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [1:0] req_phase,
    input wire logic [21:0] req_code,
    input wire logic req_over,
    input wire logic req_under,
    output logic conv_valid,
    output logic [1:0] conv_phase,
    output logic [21:0] conv_code,
    output logic conv_over,
    output logic conv_under
);
    // between results the lines churn so a stale value is never mistaken
    always_ff @(posedge clk) begin
        if (rst) begin
            conv_valid <= 1'b0;
            conv_phase <= 2'h0;
            conv_code <= 22'h0;
            conv_over <= 1'b0;
            conv_under <= 1'b0;
        end else if (req) begin
            conv_valid <= 1'b1;
            conv_phase <= req_phase;
            conv_code <= req_code;
            conv_over <= req_over;
            conv_under <= req_under;
        end else begin
            conv_valid <= 1'b0;
            conv_phase <= conv_phase + 2'h1;
            conv_code <= ~conv_code;
            conv_over <= ~conv_over;
            conv_under <= ~conv_under;
        end
    end
endmodule : apcf_conv_model

// ==== verification/apcf_top_tb_top.sv ====
`timescale 1ns/1ps
`include "apcf_regs.svh"
module apcf_top_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic [1:0] phase_sel = 2'h0;
    logic req = 1'b0;
    logic [1:0] req_phase = 2'h0;
    logic [21:0] req_code = 22'h0;
    logic [1:0] req_rng = 2'h0;
    logic avs_waitrequest, conv_valid, conv_over, conv_under, pol, irq;
    logic [1:0] conv_phase;
    logic [21:0] conv_code;
    logic [2:0] cap;
    logic [4:0] mag;
    apcf_pkg::apcf_phase_kind_type kind;
    int err_total = 0;
    int n_tests = 0;
    // a row: ctrl, cap word, phase, expected cap code, expected kind
    typedef struct packed {
        logic [1:0] ctrl;
        logic [7:0] cap;
        logic [1:0] ph;
        logic [2:0] cap_exp;
        apcf_pkg::apcf_phase_kind_type kind;
    } apcf_row_type;
    apcf_row_type rows [8] = '{
        '{2'h0, 8'h75, 2'h0, 3'h5, apcf_pkg::PK_LED2},
        '{2'h0, 8'h75, 2'h1, 3'h5, apcf_pkg::PK_AMB2},
        '{2'h0, 8'h05, 2'h3, 3'h5, apcf_pkg::PK_AMB1},
        '{2'h1, 8'h75, 2'h0, 3'h7, apcf_pkg::PK_LED2},
        '{2'h1, 8'h75, 2'h2, 3'h5, apcf_pkg::PK_LED1},
        '{2'h3, 8'h75, 2'h1, 3'h7, apcf_pkg::PK_LED3},
        '{2'h3, 8'h30, 2'h3, 3'h0, apcf_pkg::PK_AMB1},
        '{2'h2, 8'h07, 2'h2, 3'h7, apcf_pkg::PK_LED1}};
    // results: code, {over, under}, expected word
    logic [21:0] r_code [4] = '{22'h0fffff, 22'h200000, 22'h1, 22'h3fffff};
    logic [1:0] r_rng [4] = '{2'b00, 2'b00, 2'b10, 2'b01};
    logic [23:0] r_exp [4] = '{24'h0fffff, 24'he00000, 24'h3fffff, 24'hc00000};

    apcf_top u_apcf_top (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .phase_sel(phase_sel),
        .conv_valid(conv_valid), .conv_phase(conv_phase),
        .conv_code(conv_code), .conv_over(conv_over),
        .conv_under(conv_under), .active_cap_select(cap),
        .offset_current_magnitude(mag), .offset_current_polarity(pol),
        .phase_kind(kind), .irq(irq));
    apcf_conv_model u_apcf_conv_model (.clk(clk), .rst(rst), .req(req),
        .req_phase(req_phase), .req_code(req_code), .req_over(req_rng[1]),
        .req_under(req_rng[0]), .conv_valid(conv_valid),
        .conv_phase(conv_phase), .conv_code(conv_code),
        .conv_over(conv_over), .conv_under(conv_under));

    initial begin
        forever #10 clk = ~clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one avalon cycle; request held until waitrequest is sampled low
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // only the watchdog ends a wait that never completes
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // outputs follow the phase one edge later
    task ph(input logic [1:0] p);
        @(posedge clk);
        phase_sel <= p;
        @(posedge clk);
        #1;
    endtask : ph

    task complete_run;
        $display("Checks %0d, errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk(32'({avs_waitrequest, irq, cap, mag, pol, kind}), 32'h2000);
        bus(1'b0, `APCF_CAP_OFS, 32'h0);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, `APCF_CTRL_OFS, {30'h0, rows[i].ctrl});
            bus(1'b1, `APCF_CAP_OFS, {24'h0, rows[i].cap});
            ph(rows[i].ph);
            chk({29'h0, cap}, {29'h0, rows[i].cap_exp});
            chk({29'h0, kind}, {29'h0, rows[i].kind});
        end
        // last row leaves slot 2 live with three LEDs
        bus(1'b0, `APCF_PHASE_OFS, 32'h0);
        chk(rd, 32'h13);
        // odd phases negative, each phase its own magnitude
        for (int p = 0; p < 4; p++)
            bus(1'b1, `APCF_OFF0_OFS + 6'(4 * p),
                {24'h0, p[0], 2'b00, 5'(11 + 6 * p)});
        bus(1'b0, `APCF_OFF0_OFS + 6'h0c, 32'h0);
        chk(rd, 32'h9d);
        for (int p = 3; p >= 0; p--) begin
            ph(2'(p));
            chk({26'h0, pol, mag}, {26'h0, p[0], 5'(11+6*p)});
        end
        // four results back to back, one per cycle
        for (int p = 0; p < 4; p++) begin
            @(posedge clk);
            req <= 1'b1;
            req_phase <= 2'(p);
            req_code <= r_code[p];
            req_rng <= r_rng[p];
        end
        @(posedge clk);
        req <= 1'b0;
        repeat (3) @(posedge clk);
        for (int p = 0; p < 4; p++) begin
            bus(1'b0, `APCF_RES0_OFS + 6'(4 * p), 32'h0);
            chk(rd, {8'h00, r_exp[p]});
        end
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, `APCF_IRQ_STAT_OFS, 32'h0);
        chk(rd, 32'hcf);
        bus(1'b1, `APCF_IRQ_MASK_OFS, 32'h40);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, `APCF_IRQ_MASK_OFS, 32'h0);
        chk(rd, 32'h40);
        bus(1'b1, `APCF_IRQ_STAT_OFS, 32'h40);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, `APCF_IRQ_STAT_OFS, 32'h0);
        chk(rd, 32'h8f);
        // unmapped reads zero, result words are read only
        bus(1'b0, 6'h34, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, `APCF_RES0_OFS, 32'hffffffff);
        bus(1'b0, `APCF_RES0_OFS, 32'h0);
        chk(rd, 32'h000fffff);
        // mid-run reset returns every register to its reset value
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk(32'({avs_waitrequest, irq, cap, mag, pol, kind}), 32'h2000);
        bus(1'b0, `APCF_RES0_OFS, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, `APCF_IRQ_STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        complete_run();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule : apcf_top_tb_top
